//--- hw/pattern_loop_pkg.sv
package pattern_loop_pkg;

    // register addresses
    localparam logic [7:0] pattern_detect_control_addr = 8'h11;
    localparam logic [7:0] custom_pattern_low_addr     = 8'h12;
    localparam logic [7:0] custom_pattern_mid_addr     = 8'h13;
    localparam logic [7:0] custom_pattern_high_addr    = 8'h14;
    localparam logic [7:0] inband_code_lengths_addr    = 8'h15;
    localparam logic [7:0] inband_gen_code_addr        = 8'h16;
    localparam logic [7:0] inband_activate_code_addr   = 8'h17;
    localparam logic [7:0] inband_deactivate_code_addr = 8'h18;
    localparam logic [7:0] loopback_control_addr       = 8'h19;
    localparam logic [7:0] loopback_status_addr        = 8'h1c;

    // values after reset
    localparam logic [7:0] pattern_detect_control_rst = 8'h03;
    localparam logic [7:0] custom_pattern_byte_rst    = 8'h55;
    localparam logic [7:0] inband_code_lengths_rst    = 8'h01;
    localparam logic [7:0] inband_gen_code_rst        = 8'h01;
    localparam logic [7:0] inband_activate_code_rst   = 8'h01;
    localparam logic [7:0] inband_deactivate_code_rst = 8'h09;
    localparam logic [7:0] loopback_control_rst       = 8'h00;

    // pattern_detect_control fields
    localparam int detect_direction_sel_bit = 3;
    localparam int detect_data_invert_bit   = 2;
    localparam int detect_pattern_lsb       = 0;

    // inband_code_lengths fields
    localparam int gen_code_length_lsb        = 4;
    localparam int activate_code_length_lsb   = 2;
    localparam int deactivate_code_length_lsb = 0;
    localparam logic [3:0] code_length_base   = 4'd5;

    // loopback_control fields
    localparam int automatic_loopback_en_bit = 3;
    localparam int digital_loopback_en_bit   = 2;
    localparam int remote_loopback_en_bit    = 1;
    localparam int analog_loopback_en_bit    = 0;

    // detect pattern selection codes
    localparam logic [1:0] sel_qrss20 = 2'b00;
    localparam logic [1:0] sel_prbs15 = 2'b01;
    localparam logic [1:0] sel_prbs11 = 2'b10;
    localparam logic [1:0] sel_custom = 2'b11;

    // pattern lock thresholds, in bits
    localparam logic [5:0] lock_good_bits = 6'd32;
    localparam logic [3:0] loss_bad_bits  = 4'd8;

    // inband code hold time before automatic loopback changes
    localparam longint loop_hold_ms      = 5100;
    localparam longint core_clk_khz      = 125000;
    localparam longint loop_hold_cycles  = loop_hold_ms * core_clk_khz;

    typedef enum logic {hunt, locked} sync_state_t;

endpackage : pattern_loop_pkg

//--- hw/pattern_detect_inband_loopback.sv
`timescale 1ns/1ps
// Behaviour
// - Direction bit 0 (reset) watches receive, 1 watches transmit.
// - Inversion bit 1 inverts monitored data before comparison.
// - Pattern field: 00 QRSS20, 01 PRBS15, 10 PRBS11, 11 custom.
// - Three bytes form the 24-bit custom pattern, bit 23 first.
// - Generation length field gives 5 to 8 low code bits.
// - Activate length field gives 5 to 8 low code bits, default 5.
// - Deactivate length field gives 5 to 8 bits, reset selects 6.
// - Active generation repeats the code, bit 0 last each time.
// - Activate code is detected with bit 0 as the last stream bit.
// - Deactivate code is detected with bit 0 as the last stream bit.
// - Auto mode enters loopback after activate held over 5.1 s.
// - Auto mode leaves loopback after deactivate held over 5.1 s.
// - Digital loopback bit 1 enables it, 0 (reset) leaves it to auto mode.
// - Remote loopback bit 1 enables it, 0 (reset) leaves it to auto mode.
// - Analog loopback bit 1 enables it, 0 (reset) disables it.
module pattern_detect_inband_loopback
#(
    parameter longint hold_cycles = pattern_loop_pkg::loop_hold_cycles
)
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    input  wire logic        rx_bit,
    input  wire logic        rx_bit_valid,
    input  wire logic        tx_bit,
    input  wire logic        tx_bit_valid,
    input  wire logic        inband_gen_en,
    input  wire logic        gen_bit_req,
    output logic             gen_bit,
    output logic      [23:0] custom_pattern,
    output logic             pattern_sync,
    output logic             pattern_error,
    output logic             digital_loopback,
    output logic             remote_loopback,
    output logic             analog_loopback
);

    localparam logic [29:0] hold_limit = 30'(hold_cycles);

    function automatic logic [3:0] code_len(input logic [1:0] sel);
        code_len = pattern_loop_pkg::code_length_base + {2'b00, sel};
    endfunction : code_len

    function automatic logic code_match(input logic [1:0] sel,
                                        input logic [7:0] code,
                                        input logic [7:0] window);
        logic [7:0] mask;
        mask = 8'hff >> (4'd8 - code_len(sel));
        code_match = ((code ^ window) & mask) == 8'h00;
    endfunction : code_match

    // reset release through two flops
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // registers
    logic [7:0] detect_ctrl;
    logic [7:0] pat_low;
    logic [7:0] pat_mid;
    logic [7:0] pat_high;
    logic [7:0] code_lengths;
    logic [7:0] gen_code_bits;
    logic [7:0] activate_code_bits;
    logic [7:0] deactivate_code_bits;
    logic [7:0] loop_ctrl;

    wire wr_detect = reg_write &&
        reg_addr == pattern_loop_pkg::pattern_detect_control_addr;
    wire wr_low    = reg_write &&
        reg_addr == pattern_loop_pkg::custom_pattern_low_addr;
    wire wr_mid    = reg_write &&
        reg_addr == pattern_loop_pkg::custom_pattern_mid_addr;
    wire wr_high   = reg_write &&
        reg_addr == pattern_loop_pkg::custom_pattern_high_addr;
    wire wr_len    = reg_write &&
        reg_addr == pattern_loop_pkg::inband_code_lengths_addr;
    wire wr_gen    = reg_write &&
        reg_addr == pattern_loop_pkg::inband_gen_code_addr;
    wire wr_act    = reg_write &&
        reg_addr == pattern_loop_pkg::inband_activate_code_addr;
    wire wr_deact  = reg_write &&
        reg_addr == pattern_loop_pkg::inband_deactivate_code_addr;
    wire wr_loop   = reg_write &&
        reg_addr == pattern_loop_pkg::loopback_control_addr;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            detect_ctrl <= pattern_loop_pkg::pattern_detect_control_rst;
            pat_low     <= pattern_loop_pkg::custom_pattern_byte_rst;
            pat_mid     <= pattern_loop_pkg::custom_pattern_byte_rst;
            pat_high    <= pattern_loop_pkg::custom_pattern_byte_rst;
            code_lengths <= pattern_loop_pkg::inband_code_lengths_rst;
            gen_code_bits <= pattern_loop_pkg::inband_gen_code_rst;
            activate_code_bits <=
                pattern_loop_pkg::inband_activate_code_rst;
            deactivate_code_bits <=
                pattern_loop_pkg::inband_deactivate_code_rst;
            loop_ctrl <= pattern_loop_pkg::loopback_control_rst;
        end
        else
        begin
            if (wr_detect)
                detect_ctrl <= {4'h0, reg_wdata[3:0]};
            if (wr_low)
                pat_low <= reg_wdata;
            if (wr_mid)
                pat_mid <= reg_wdata;
            if (wr_high)
                pat_high <= reg_wdata;
            if (wr_len)
                code_lengths <= {2'b00, reg_wdata[5:0]};
            if (wr_gen)
                gen_code_bits <= reg_wdata;
            if (wr_act)
                activate_code_bits <= reg_wdata;
            if (wr_deact)
                deactivate_code_bits <= reg_wdata;
            if (wr_loop)
                loop_ctrl <= {4'h0, reg_wdata[3:0]};
        end
    end

    // control fields
    wire       dir_tx    =
        detect_ctrl[pattern_loop_pkg::detect_direction_sel_bit];
    wire       invert    =
        detect_ctrl[pattern_loop_pkg::detect_data_invert_bit];
    wire [1:0] pat_sel   =
        detect_ctrl[pattern_loop_pkg::detect_pattern_lsb +: 2];
    wire [1:0] gen_len   =
        code_lengths[pattern_loop_pkg::gen_code_length_lsb +: 2];
    wire [1:0] act_len   =
        code_lengths[pattern_loop_pkg::activate_code_length_lsb +: 2];
    wire [1:0] deact_len =
        code_lengths[pattern_loop_pkg::deactivate_code_length_lsb +: 2];
    wire       auto_en   =
        loop_ctrl[pattern_loop_pkg::automatic_loopback_en_bit];

    // custom pattern, bit 23 leads
    wire [23:0] pattern_word = {pat_high, pat_mid, pat_low};

    // monitored stream
    wire mon_valid = dir_tx ? tx_bit_valid : rx_bit_valid;
    wire mon_raw   = dir_tx ? tx_bit : rx_bit;
    wire mon_bit   = mon_raw ^ invert;

    // pattern checker
    logic [23:0]  history;
    logic [4:0]   pat_ptr;
    logic [5:0]   good_cnt;
    logic [3:0]   bad_cnt;
    pattern_loop_pkg::sync_state_t sync_state;
    pattern_loop_pkg::sync_state_t next_sync_state;

    wire is_custom  = pat_sel == pattern_loop_pkg::sel_custom;
    wire prbs_guess =
        (pat_sel == pattern_loop_pkg::sel_qrss20) ?
            history[19] ^ history[16] :
        (pat_sel == pattern_loop_pkg::sel_prbs15) ?
            history[14] ^ history[13] :
            history[10] ^ history[8];
    wire expect_bit = is_custom ? pattern_word[pat_ptr] : prbs_guess;
    wire bit_ok     = mon_bit == expect_bit;
    wire [23:0] next_history = {history[22:0], mon_bit};
    wire custom_hit = next_history == pattern_word;
    wire is_locked  = sync_state == pattern_loop_pkg::locked;
    wire [4:0] next_ptr = (is_custom && !is_locked) ? 5'd23 :
        (pat_ptr == 5'd0) ? 5'd23 : pat_ptr - 5'd1;

    always_comb
    begin
        next_sync_state = sync_state;
        unique case (sync_state)
            pattern_loop_pkg::hunt:
                if (is_custom ? custom_hit :
                    (bit_ok && good_cnt ==
                     pattern_loop_pkg::lock_good_bits - 6'd1))
                    next_sync_state = pattern_loop_pkg::locked;
            pattern_loop_pkg::locked:
                if (!bit_ok && bad_cnt ==
                    pattern_loop_pkg::loss_bad_bits - 4'd1)
                    next_sync_state = pattern_loop_pkg::hunt;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            history       <= 24'h000000;
            pat_ptr       <= 5'd23;
            good_cnt      <= 6'd0;
            bad_cnt       <= 4'd0;
            sync_state    <= pattern_loop_pkg::hunt;
            pattern_error <= 1'b0;
        end
        else if (wr_detect)
        begin
            // new selection restarts the hunt
            sync_state    <= pattern_loop_pkg::hunt;
            good_cnt      <= 6'd0;
            bad_cnt       <= 4'd0;
            pat_ptr       <= 5'd23;
            pattern_error <= 1'b0;
        end
        else if (mon_valid)
        begin
            history       <= next_history;
            pat_ptr       <= next_ptr;
            sync_state    <= next_sync_state;
            good_cnt      <= bit_ok ? good_cnt + 6'd1 : 6'd0;
            bad_cnt       <= bit_ok ? 4'd0 : bad_cnt + 4'd1;
            pattern_error <= is_locked && !bit_ok;
        end
        else
            pattern_error <= 1'b0;
    end

    assign pattern_sync = is_locked;

    // inband code detectors: 0 rx act, 1 tx act, 2 rx deact, 3 tx deact
    logic [7:0] rx_window;
    logic [7:0] tx_window;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rx_window <= 8'h00;
            tx_window <= 8'h00;
        end
        else
        begin
            if (rx_bit_valid)
                rx_window <= {rx_window[6:0], rx_bit};
            if (tx_bit_valid)
                tx_window <= {tx_window[6:0], tx_bit};
        end
    end

    logic [3:0] code_held;
    logic [3:0] code_seen;

    genvar d;
    generate
        for (d = 0; d < 4; d++)
        begin : g_code
            logic [3:0]  since;
            logic [29:0] timer;
            wire         path_tx = d[0];
            wire         stb     = path_tx ? tx_bit_valid : rx_bit_valid;
            wire [7:0]   win_now = path_tx ?
                {tx_window[6:0], tx_bit} : {rx_window[6:0], rx_bit};
            wire [1:0]   len     = (d < 2) ? act_len : deact_len;
            wire [7:0]   code    = (d < 2) ?
                activate_code_bits : deactivate_code_bits;
            // newest bit compared against code bit 0
            wire         hit     =
                code_match(len, code, win_now);
            wire         seen    = since < code_len(len);

            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                    since <= 4'hf;
                else if (stb)
                    since <= hit ? 4'h0 :
                        (since == 4'hf) ? since : since + 4'h1;
            end

            always_ff @(posedge core_clk or negedge rst_n)
            begin
                if (!rst_n)
                    timer <= 30'd0;
                else if (!seen)
                    timer <= 30'd0;
                else if (timer != hold_limit)
                    timer <= timer + 30'd1;
            end

            assign code_seen[d] = seen;
            assign code_held[d] = seen && timer == hold_limit;
        end
    endgenerate

    // automatic loopback state
    logic auto_digital;
    logic auto_remote;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            auto_digital <= 1'b0;
            auto_remote  <= 1'b0;
        end
        else if (!auto_en)
        begin
            auto_digital <= 1'b0;
            auto_remote  <= 1'b0;
        end
        else
        begin
            // entry wins over leaving when both hold
            if (code_held[1])
                auto_digital <= 1'b1;
            else if (code_held[3])
                auto_digital <= 1'b0;
            if (code_held[0])
                auto_remote <= 1'b1;
            else if (code_held[2])
                auto_remote <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            digital_loopback <= 1'b0;
            remote_loopback  <= 1'b0;
            analog_loopback  <= 1'b0;
        end
        else
        begin
            digital_loopback <= auto_digital ||
                loop_ctrl[pattern_loop_pkg::digital_loopback_en_bit];
            remote_loopback  <= auto_remote ||
                loop_ctrl[pattern_loop_pkg::remote_loopback_en_bit];
            analog_loopback  <=
                loop_ctrl[pattern_loop_pkg::analog_loopback_en_bit];
        end
    end

    // inband code generator
    logic [2:0] gen_idx;
    wire  [2:0] gen_top = 3'(code_len(gen_len) - 4'd1);

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gen_idx <= 3'd4;
            gen_bit <= 1'b0;
        end
        else if (!inband_gen_en)
        begin
            gen_idx <= gen_top;
            gen_bit <= 1'b0;
        end
        else if (gen_bit_req)
        begin
            gen_bit <= gen_code_bits[gen_idx];
            gen_idx <= (gen_idx == 3'd0) ? gen_top : gen_idx - 3'd1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            custom_pattern <= 24'h000000;
        else
            custom_pattern <= pattern_word;
    end

    // read path
    wire       dir_act   = dir_tx ? code_seen[1] : code_seen[0];
    wire       dir_deact = dir_tx ? code_seen[3] : code_seen[2];
    wire [7:0] status    = {3'b000, auto_remote, auto_digital,
                            dir_deact, dir_act, is_locked};
    wire [7:0] read_mux  =
        (reg_addr == pattern_loop_pkg::pattern_detect_control_addr) ?
            detect_ctrl :
        (reg_addr == pattern_loop_pkg::custom_pattern_low_addr) ?
            pat_low :
        (reg_addr == pattern_loop_pkg::custom_pattern_mid_addr) ?
            pat_mid :
        (reg_addr == pattern_loop_pkg::custom_pattern_high_addr) ?
            pat_high :
        (reg_addr == pattern_loop_pkg::inband_code_lengths_addr) ?
            code_lengths :
        (reg_addr == pattern_loop_pkg::inband_gen_code_addr) ?
            gen_code_bits :
        (reg_addr == pattern_loop_pkg::inband_activate_code_addr) ?
            activate_code_bits :
        (reg_addr == pattern_loop_pkg::inband_deactivate_code_addr) ?
            deactivate_code_bits :
        (reg_addr == pattern_loop_pkg::loopback_control_addr) ?
            loop_ctrl :
        (reg_addr == pattern_loop_pkg::loopback_status_addr) ?
            status : 8'h00;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        else
            reg_rdata <= reg_read ? read_mux : 8'h00;
    end

endmodule : pattern_detect_inband_loopback

//--- hw/unused_marker_removed.sv
`timescale 1ns/1ps

//--- dv/pattern_detect_inband_loopback_properties.sv
`timescale 1ns/1ps
module pattern_detect_inband_loopback_properties
#(
    parameter longint hold_cycles = 50
)
(
    input wire logic        core_clk,
    input wire logic        reset_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_write,
    input wire logic        rx_bit_valid,
    input wire logic        tx_bit_valid,
    input wire logic        inband_gen_en,
    input wire logic        gen_bit_req,
    input wire logic        gen_bit,
    input wire logic [23:0] custom_pattern,
    input wire logic        pattern_sync,
    input wire logic        pattern_error,
    input wire logic        digital_loopback,
    input wire logic        remote_loopback,
    input wire logic        analog_loopback
);
    logic [3:0] loop_reg;
    logic       dir;
    wire        loop_wr = reg_write && reg_addr == 8'h19;
    wire        ctl_wr  = reg_write && reg_addr == 8'h11;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // shadow of the loopback and direction bits
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            loop_reg <= 4'h0;
            dir      <= 1'b0;
        end
        else
        begin
            if (loop_wr)
                loop_reg <= reg_wdata[3:0];
            if (ctl_wr)
                dir <= reg_wdata[3];
        end
    end
    AST_ANALOG_SET: assert property (
        loop_wr |-> ##2 analog_loopback == $past(reg_wdata[0], 2))
        else $error("analog loopback does not follow its bit");
    AST_REMOTE_SET: assert property (
        loop_wr && reg_wdata[1] |-> ##2 remote_loopback)
        else $error("remote loopback not entered");
    AST_DIGITAL_SET: assert property (
        loop_wr && reg_wdata[2] |-> ##2 digital_loopback)
        else $error("digital loopback not entered");
    AST_ANALOG_HOLD: assert property (
        $changed(analog_loopback) |-> $past(loop_wr, 2))
        else $error("analog loopback changed without a write");
    AST_DIGITAL_RISE: assert property (
        $rose(digital_loopback) |-> $past(loop_reg[2]) || $past(loop_reg[3]))
        else $error("digital loopback entered without cause");
    AST_PATTERN_WORD: assert property (
        reg_write && reg_addr == 8'h14
        |-> ##2 custom_pattern[23:16] == $past(reg_wdata, 2))
        else $error("high pattern byte misplaced");
    AST_SYNC_DIR: assert property (
        $rose(pattern_sync) |-> $past(dir ? tx_bit_valid : rx_bit_valid))
        else $error("lock from the unselected path");
    AST_RESTART: assert property (
        ctl_wr |=> !pattern_sync)
        else $error("checker kept lock after control write");
    AST_ERR_LOCKED: assert property (
        pattern_error |-> $past(pattern_sync))
        else $error("bit error flagged while hunting");
    AST_GEN_OFF: assert property (
        !inband_gen_en |=> !gen_bit)
        else $error("generated bit high while idle");
    AST_GEN_HOLD: assert property (
        inband_gen_en && !gen_bit_req |=> $stable(gen_bit))
        else $error("generated bit moved without request");
    COV_SYNC: cover property ($rose(pattern_sync));
    COV_DIGITAL: cover property ($rose(digital_loopback));
    COV_GEN: cover property ($rose(gen_bit));
endmodule : pattern_detect_inband_loopback_properties

bind pattern_detect_inband_loopback pattern_detect_inband_loopback_properties
    #(.hold_cycles(hold_cycles)) props_inst (.*);

//--- dv/line_partner.sv
`timescale 1ns/1ps
module line_partner
(
    input  wire logic core_clk,
    output logic      rx_bit,
    output logic      rx_bit_valid,
    output logic      tx_bit,
    output logic      tx_bit_valid
);
    logic rx_data  = 1'b0;
    logic tx_data  = 1'b0;
    logic idle_bit = 1'b0;
    initial rx_bit_valid = 1'b0;
    initial tx_bit_valid = 1'b0;
    always @(posedge core_clk)
        idle_bit <= ~idle_bit;
    // between bits the lines toggle so a stale bit never passes for data
    assign rx_bit = rx_bit_valid ? rx_data : idle_bit;
    assign tx_bit = tx_bit_valid ? tx_data : idle_bit;
    task automatic send_bit(input logic path, input logic b);
        @(posedge core_clk);
        if (path)
        begin
            tx_data      <= b;
            tx_bit_valid <= 1'b1;
        end
        else
        begin
            rx_data      <= b;
            rx_bit_valid <= 1'b1;
        end
        @(posedge core_clk);
        tx_bit_valid <= 1'b0;
        rx_bit_valid <= 1'b0;
    endtask : send_bit
    task automatic send_code(input logic path, input logic [7:0] code,
                             input int len, input int reps);
        for (int r = 0; r < reps; r++)
            for (int i = len - 1; i >= 0; i--)
                send_bit(path, code[i]);
    endtask : send_code
endmodule : line_partner

//--- dv/pattern_detect_inband_loopback_tb.sv
`timescale 1ns/1ps
module pattern_detect_inband_loopback_tb;
    logic        core_clk      = 1'b0;
    logic        reset_n       = 1'b0;
    logic [7:0]  reg_addr      = 8'h00;
    logic [7:0]  reg_wdata     = 8'h00;
    logic        reg_write     = 1'b0;
    logic        reg_read      = 1'b0;
    logic        inband_gen_en = 1'b0;
    logic        gen_bit_req   = 1'b0;
    logic [7:0]  reg_rdata;
    logic        rx_bit, rx_bit_valid, tx_bit, tx_bit_valid, gen_bit;
    logic [23:0] custom_pattern;
    logic        pattern_sync, pattern_error;
    logic        digital_loopback, remote_loopback, analog_loopback;
    int          error_cnt = 0;
    int          checked   = 0;
    logic [7:0]  rst_tab [9] = '{8'h03, 8'h55, 8'h55, 8'h55, 8'h01,
                                 8'h01, 8'h01, 8'h09, 8'h00};
    always #4 core_clk = ~core_clk;
    pattern_detect_inband_loopback #(.hold_cycles(50))
        pattern_detect_inband_loopback_inst (.*);
    line_partner line_partner_inst (.*);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask : rd
    function automatic logic lb(input int p);
        return p ? digital_loopback : remote_loopback;
    endfunction : lb
    task automatic send_pat(input logic path, input logic [23:0] p);
        for (int i = 23; i >= 0; i--)
            line_partner_inst.send_bit(path, p[i]);
        #1;
    endtask : send_pat
    task automatic t_regs;
        for (int i = 0; i < 9; i++)
            rd(8'(8'h11 + i), rst_tab[i]);
        check(custom_pattern, 24'h555555);
        rd(8'h1a, 8'h00);
        wr(8'h11, 8'hff);
        rd(8'h11, 8'h0f);
        wr(8'h19, 8'h07);
        repeat (2) @(posedge core_clk);
        #1;
        check({digital_loopback, remote_loopback, analog_loopback}, 3'h7);
        wr(8'h19, 8'h00);
        repeat (2) @(posedge core_clk);
        #1;
        check({digital_loopback, remote_loopback, analog_loopback}, 3'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_custom;
        wr(8'h14, 8'ha5);
        wr(8'h13, 8'h3c);
        wr(8'h12, 8'h0f);
        wr(8'h11, 8'h03);
        check(custom_pattern, 24'ha53c0f);
        send_pat(1'b0, 24'ha53c0f);
        check(pattern_sync, 1'b1);
        wr(8'h11, 8'h0b);
        send_pat(1'b0, 24'ha53c0f);
        check(pattern_sync, 1'b0);
        send_pat(1'b1, 24'ha53c0f);
        check(pattern_sync, 1'b1);
        wr(8'h11, 8'h07);
        send_pat(1'b0, ~24'ha53c0f);
        check(pattern_sync, 1'b1);
        line_partner_inst.send_bit(1'b0, 1'b1);
        #1;
        check(pattern_error, 1'b1);
        $display("test custom done");
    endtask : t_custom
    task automatic t_prbs;
        int          t1;
        int          t2;
        logic [19:0] h;
        logic        nb;
        for (int s = 0; s < 3; s++)
        begin
            t1 = (s == 0) ? 20 : (s == 1) ? 15 : 11;
            t2 = (s == 0) ? 17 : (s == 1) ? 14 : 9;
            h  = 20'hfffff;
            wr(8'h11, 8'(s));
            for (int i = 0; i < 80; i++)
            begin
                nb = (i < t1) ? 1'b1 : h[t1 - 1] ^ h[t2 - 1];
                h  = {h[18:0], nb};
                line_partner_inst.send_bit(1'b0, nb);
            end
            #1;
            check(pattern_sync, 1'b1);
        end
        $display("test prbs done");
    endtask : t_prbs
    task automatic t_gen;
        int         n;
        logic [7:0] c = 8'hb5;
        for (int l = 0; l < 4; l++)
        begin
            n = l + 5;
            wr(8'h15, 8'(l << 4));
            wr(8'h16, c);
            inband_gen_en <= 1'b1;
            for (int i = 0; i < 2 * n; i++)
            begin
                @(posedge core_clk);
                gen_bit_req <= 1'b1;
                @(posedge core_clk);
                gen_bit_req <= 1'b0;
                #1;
                check(gen_bit, c[n - 1 - i % n]);
            end
            @(posedge core_clk);
            inband_gen_en <= 1'b0;
        end
        $display("test gen done");
    endtask : t_gen
    task automatic t_auto;
        wr(8'h15, 8'h0d);
        wr(8'h17, 8'h96);
        wr(8'h18, 8'h2b);
        line_partner_inst.send_code(1'b0, 8'h00, 8, 1);
        line_partner_inst.send_code(1'b1, 8'h00, 8, 1);
        wr(8'h19, 8'h08);
        for (int p = 0; p < 2; p++)
        begin
            line_partner_inst.send_code(p[0], 8'h96, 8, 2);
            line_partner_inst.send_code(p[0], 8'h00, 3, 1);
            line_partner_inst.send_code(p[0], 8'h96, 8, 2);
            #1;
            check(lb(p), 1'b0);
            line_partner_inst.send_code(p[0], 8'h96, 8, 30);
            repeat (2) @(posedge core_clk);
            #1;
            check(lb(p), 1'b1);
            line_partner_inst.send_code(p[0], 8'h2b, 6, 30);
            repeat (2) @(posedge core_clk);
            #1;
            check(lb(p), 1'b0);
        end
        wr(8'h19, 8'h00);
        $display("test auto done");
    endtask : t_auto
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop
    initial
    begin
        #400000;
        error_cnt++;
        report_and_stop();
    end
    initial
    begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs();
        t_custom();
        t_prbs();
        t_gen();
        t_auto();
        report_and_stop();
    end
endmodule : pattern_detect_inband_loopback_tb
